// ==== bench/stid_props.sv ====
// Timing and fault checks on the protection-control decoder ports
`timescale 1ns/1ns
module stid_props (
    // Inputs and context
    input logic clk_sys_in, rstn_in, instr_valid_in,
    input logic [7:0] escape_byte_in, opcode_byte_in, modrm_byte_in,
    input logic page_granular_in, protected_mode_in,
    input logic [1:0] current_privilege_level_in,
    input logic operand_is_stack_in,
    input logic [16:0] operand_end_offset_in,
    input logic limit_violation_in, rights_violation_in, selector_priv_violation_in, descriptor_fetch_in,
    // Results
    input logic busy_out,
    input logic [3:0] op_code_out,
    input logic done_out, fault_out,
    input logic [7:0] fault_vector_out,
    input logic zero_flag_clear_out, bus_lock_out
);
default clocking @(posedge clk_sys_in); endclocking
default disable iff (!rstn_in);
// Taken instruction and its fields
wire tk = instr_valid_in && !busy_out && escape_byte_in == 8'h0F;
wire [2:0] rg = modrm_byte_in[5:3];
wire rm = modrm_byte_in[7:6] == 2'h3;
wire g1 = tk && opcode_byte_in == 8'h01 && rm;
wire pm = protected_mode_in;
store_base_time_a: assert property (g1 && rg == 3'h0 |=> busy_out[*8] ##1 busy_out ##1 done_out && !busy_out)
    else $error("store base timing wrong");
status_store_time_a: assert property (g1 && rg == 3'h4 |=> busy_out ##1 busy_out ##1 done_out)
    else $error("status store timing wrong");
real_prot_only_a: assert property (tk && !pm && (opcode_byte_in == 8'h03 || opcode_byte_in == 8'h00 && rg < 3'h6)
    |-> ##[1:2] fault_out && fault_vector_out == 8'h06) else $error("no invalid opcode fault");
done_at_end_a: assert property ($fell(busy_out) |-> done_out) else $error("end without done");
fault_pulse_a: assert property (fault_out && !instr_valid_in |=> !fault_out) else $error("fault pulse too long");
lock_cause_a: assert property (bus_lock_out |-> descriptor_fetch_in && busy_out) else $error("stray lock");
priv_load_a: assert property (g1 && pm && current_privilege_level_in != 2'h0 && rg == 3'h3
    |-> ##[1:2] fault_out && fault_vector_out == 8'h0D) else $error("privileged load not faulted");
zero_clear_a: assert property (tk && pm && selector_priv_violation_in && opcode_byte_in == 8'h00 && rg[2:1] == 2'h2
    && rm |-> ##[1:2] zero_flag_clear_out && !fault_out) else $error("zero flag not cleared");
real_stack_a: assert property (tk && !pm && opcode_byte_in == 8'h01 && rg == 3'h0 && !rm && operand_is_stack_in
    && operand_end_offset_in > 17'h0FFFF |-> ##[1:2] fault_out && fault_vector_out == 8'h0C) else $error("no stack fault");
endmodule // stid_props
bind stid_decode stid_props stid_props_i (.*);

// ==== bench/tb_stid_decode.sv ====
// Self-checking bench for the protection-control decoder
`timescale 1ns/1ns
module tb_stid_decode;
logic clk_sys_in = 0, rstn_in = 0, instr_valid_in = 0, page_granular_in = 0, protected_mode_in = 0;
logic operand_is_stack_in = 0, limit_violation_in = 0, rights_violation_in = 0;
logic selector_priv_violation_in = 0, descriptor_fetch_in = 0;
logic [7:0] escape_byte_in = 0, opcode_byte_in = 0, modrm_byte_in = 0, fault_vector_out, n, f, z, l, d;
logic [1:0] current_privilege_level_in = 0;
logic [16:0] operand_end_offset_in = 0;
logic busy_out, done_out, fault_out, zero_flag_clear_out, bus_lock_out;
logic [3:0] op_code_out;
int error_cnt = 0, samples_checked = 0;
// Opcode (bit 4 = page granular), reg field, register count, memory count
logic [31:0] tab [13] = '{32'h01000909, 32'h01010909, 32'h01030B0B, 32'h01040202, 32'h01060B0E, 32'h00000202,
    32'h00010202, 32'h00021418, 32'h0003171B, 32'h00040A0B, 32'h00050F10, 32'h03001516, 32'h1300191A};
// Op code expected for each table row, in the decoder's own numbering
logic [3:0] opc [13] = '{4'h7, 4'h8, 4'h1, 4'hA, 4'h3, 4'h9, 4'hB, 4'h2, 4'h6, 4'hC, 4'hD, 4'h4, 4'h5};
always #5 clk_sys_in = ~clk_sys_in;
stid_decode stid_decode_i (.*);
task chk(input string s, input logic [7:0] e, g);
    samples_checked++;
    if (e !== g) begin error_cnt++; $display("[ERR] %s exp %h got %h", s, e, g); end
endtask
// One instruction, then watch long enough for the slowest one to end
task run(input logic [7:0] o, m);
    @(posedge clk_sys_in) #1;
    instr_valid_in = 1; escape_byte_in = 8'h0F; opcode_byte_in = {4'h0, o[3:0]};
    page_granular_in = o[4]; modrm_byte_in = m;
    @(posedge clk_sys_in) #1;
    instr_valid_in = 0; n = 0; f = 0; z = 0; l = 0; d = 0;
    repeat (32) begin
        n += busy_out; f |= fault_out; z |= zero_flag_clear_out; l |= bus_lock_out; d += done_out;
        @(posedge clk_sys_in) #1;
    end
endtask
// Every operation, both modes, register and memory operands
task t_table;
    for (int p = 0; p < 2; p++) for (int i = 0; i < 13; i++) for (int k = 0; k < 2; k++) begin
        protected_mode_in = p[0];
        run(tab[i][31:24], {k ? 2'h0 : 2'h3, tab[i][18:16], 3'h0});
        chk("opcode", {4'h0, opc[i]}, {4'h0, op_code_out});
        if (p == 1 || tab[i][27:24] == 4'h1) begin
            chk("done", 8'h01, d);
            chk("clocks", k ? tab[i][7:0] : tab[i][15:8], n);
            chk("fault", 8'h00, f);
        end else chk("vector", 8'h06, fault_vector_out);
    end
endtask
// Real overruns, priority, protected violations, privilege
task t_faults;
    protected_mode_in = 0; operand_end_offset_in = 17'h10000;
    run(8'h01, 8'h00); chk("vector", 8'h0D, fault_vector_out);
    operand_is_stack_in = 1;
    run(8'h01, 8'h00); chk("vector", 8'h0C, fault_vector_out);
    run(8'h03, 8'h00); chk("vector", 8'h06, fault_vector_out);
    protected_mode_in = 1; operand_end_offset_in = 0; limit_violation_in = 1;
    run(8'h01, 8'h08); chk("vector", 8'h0C, fault_vector_out);
    operand_is_stack_in = 0; limit_violation_in = 0; rights_violation_in = 1;
    run(8'h01, 8'h08); chk("vector", 8'h0D, fault_vector_out);
    rights_violation_in = 0; current_privilege_level_in = 2'h3;
    run(8'h01, 8'hD8); chk("fault", 8'h01, f);
    current_privilege_level_in = 0;
endtask
// Selector privilege on verify, lock during descriptor fetch
task t_zero_lock;
    selector_priv_violation_in = 1;
    run(8'h00, 8'hE0); chk("zero", 8'h01, z); chk("fault", 8'h00, f);
    selector_priv_violation_in = 0; descriptor_fetch_in = 1;
    run(8'h00, 8'hD0); chk("lock", 8'h01, l);
    run(8'h01, 8'hE0); chk("lock", 8'h00, l);
    descriptor_fetch_in = 0;
endtask
task finish_test;
    $display("checked %0d errors %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
endtask
initial begin
    repeat (10) @(posedge clk_sys_in);
    #1 rstn_in = 1;
    t_table; t_faults; t_zero_lock; finish_test;
end
// Runs take about 2,100 cycles; cut off well past that
initial begin
    #100000 error_cnt++;
    finish_test;
end
endmodule // tb_stid_decode

// ==== hw/stid_decode.v ====
// Decoder and execution timer for the protection-control instruction group
`timescale 1ns/1ns
`include "stid_regs.vh"
module stid_decode
(
    // Clock and reset
    input wire clk_sys_in,
    input wire rstn_in,
    // Instruction bytes and context
    input wire instr_valid_in,
    input wire [7:0] escape_byte_in,
    input wire [7:0] opcode_byte_in,
    input wire [7:0] modrm_byte_in,
    input wire page_granular_in,
    input wire protected_mode_in,
    input wire [1:0] current_privilege_level_in,
    // Operand check inputs
    input wire operand_is_stack_in,
    input wire [16:0] operand_end_offset_in,
    input wire limit_violation_in,
    input wire rights_violation_in,
    input wire selector_priv_violation_in,
    input wire descriptor_fetch_in,
    // Results
    output wire busy_out,
    output reg [3:0] op_code_out,
    output reg done_out,
    output reg fault_out,
    output reg [7:0] fault_vector_out,
    output reg zero_flag_clear_out,
    output wire bus_lock_out
);

    // Ops that need a table descriptor fetch
    function needs_desc;
        input [3:0] op;
        begin
            needs_desc = (op == `STID_OPS_LOAD_LOCAL_SEL) ||
                (op == `STID_OPS_LOAD_TASK) ||
                (op == `STID_OPS_LIMIT_BYTE) ||
                (op == `STID_OPS_LIMIT_PAGE) ||
                (op == `STID_OPS_VERIFY_READ) ||
                (op == `STID_OPS_VERIFY_WRITE);
        end
    endfunction

    // Ops reporting selector privilege through the zero flag
    function is_verify;
        input [3:0] op;
        begin
            is_verify = (op == `STID_OPS_LIMIT_BYTE) ||
                (op == `STID_OPS_LIMIT_PAGE) ||
                (op == `STID_OPS_VERIFY_READ) ||
                (op == `STID_OPS_VERIFY_WRITE);
        end
    endfunction

    // Pick register or memory clock count from the mod field
    function [4:0] pick_count;
        input reg_op;
        input [4:0] reg_clocks;
        input [4:0] mem_clocks;
        begin
            pick_count = reg_op ? reg_clocks : mem_clocks;
        end
    endfunction

    // Decode results
    reg [3:0] next_op;
    reg next_prot_only;
    reg next_priv;
    reg [4:0] next_count;
    // Fault decision for the byte group on the bus
    reg next_fault;
    reg [7:0] next_vector;
    // Execution state
    reg [4:0] count;
    reg active;
    reg [3:0] cur_op;
    wire reg_operand;
    wire [2:0] reg_field;
    wire real_overrun;
    wire take;

    // Mod field 11 selects a register operand
    assign reg_operand = (modrm_byte_in[7:6] == `STID_MOD_REG);
    assign reg_field = modrm_byte_in[5:3];

    // Opcode decode and clock count selection
    always @*
    begin
        next_op = `STID_OPS_NONE;
        next_prot_only = 1'b0;
        next_priv = 1'b0;
        next_count = 5'h00;
        if (escape_byte_in == `STID_ESCAPE && opcode_byte_in == `STID_OP_GRP1)
        begin
            // Table base and status word group, legal in both modes
            case (reg_field)
                // Store global base, fixed count
                3'h0:
                begin
                    next_op = `STID_OPS_STORE_GLOBAL_BASE;
                    next_count = `STID_CLK_STORE_BASE;
                end
                // Store interrupt base, fixed count
                3'h1:
                begin
                    next_op = `STID_OPS_STORE_INT_BASE;
                    next_count = `STID_CLK_STORE_BASE;
                end
                // Load interrupt base, same count for both operands
                3'h3:
                begin
                    next_op = `STID_OPS_LOAD_INT_BASE;
                    next_priv = 1'b1;
                    next_count = `STID_CLK_LOAD_INT_BASE;
                end
                // Store status word
                3'h4:
                begin
                    next_op = `STID_OPS_STORE_STATUS;
                    next_count = `STID_CLK_STORE_SHORT;
                end
                // Load status word
                3'h6:
                begin
                    next_op = `STID_OPS_LOAD_STATUS;
                    next_priv = 1'b1;
                    next_count = pick_count(reg_operand, `STID_CLK_LOAD_STATUS_REG, `STID_CLK_LOAD_STATUS_MEM);
                end
                // Unused reg values are ignored, not faulted
                default:
                begin
                    next_op = `STID_OPS_NONE;
                end
            endcase
        end
        else if (escape_byte_in == `STID_ESCAPE && opcode_byte_in == `STID_OP_GRP0)
        begin
            // Selector, task and verify group, protected mode only
            next_prot_only = 1'b1;
            case (reg_field)
                // Store local selector
                3'h0:
                begin
                    next_op = `STID_OPS_STORE_LOCAL_SEL;
                    next_count = `STID_CLK_STORE_SHORT;
                end
                // Store task register
                3'h1:
                begin
                    next_op = `STID_OPS_STORE_TASK;
                    next_count = `STID_CLK_STORE_SHORT;
                end
                // Load local selector
                3'h2:
                begin
                    next_op = `STID_OPS_LOAD_LOCAL_SEL;
                    next_priv = 1'b1;
                    next_count = pick_count(reg_operand, `STID_CLK_LOAD_LOCAL_REG, `STID_CLK_LOAD_LOCAL_MEM);
                end
                // Load task register
                3'h3:
                begin
                    next_op = `STID_OPS_LOAD_TASK;
                    next_priv = 1'b1;
                    next_count = pick_count(reg_operand, `STID_CLK_LOAD_TASK_REG, `STID_CLK_LOAD_TASK_MEM);
                end
                // Verify readable
                3'h4:
                begin
                    next_op = `STID_OPS_VERIFY_READ;
                    next_count = pick_count(reg_operand, `STID_CLK_VERIFY_READ_REG, `STID_CLK_VERIFY_READ_MEM);
                end
                // Verify writable
                3'h5:
                begin
                    next_op = `STID_OPS_VERIFY_WRITE;
                    next_count = pick_count(reg_operand, `STID_CLK_VERIFY_WRITE_REG, `STID_CLK_VERIFY_WRITE_MEM);
                end
                // Unused reg values must not raise the mode fault
                default:
                begin
                    next_prot_only = 1'b0;
                end
            endcase
        end
        else if (escape_byte_in == `STID_ESCAPE && opcode_byte_in == `STID_OP_SEG_LIMIT)
        begin
            // Limit load: count depends on the target's granularity
            next_prot_only = 1'b1;
            if (page_granular_in)
            begin
                // Page-granular limit takes the longer count
                next_op = `STID_OPS_LIMIT_PAGE;
                next_count = pick_count(reg_operand, `STID_CLK_LIMIT_PAGE_REG, `STID_CLK_LIMIT_PAGE_MEM);
            end
            else
            begin
                // Byte-granular limit
                next_op = `STID_OPS_LIMIT_BYTE;
                next_count = pick_count(reg_operand, `STID_CLK_LIMIT_BYTE_REG, `STID_CLK_LIMIT_BYTE_MEM);
            end
        end
    end

    // Real-mode overrun past the fixed limit; register operands never overrun
    assign real_overrun = !reg_operand && (operand_end_offset_in > `STID_REAL_LIMIT);

    // Requests are only looked at while idle; a busy decoder ignores them
    assign take = instr_valid_in && !active && (next_op != `STID_OPS_NONE);

    // Fault priority: invalid opcode, real overrun, protected violation, privilege
    always @*
    begin
        next_fault = 1'b0;
        next_vector = `STID_VEC_GP;
        if (!protected_mode_in && next_prot_only)
        begin
            next_fault = 1'b1;
            next_vector = `STID_VEC_UD;
        end
        else if (!protected_mode_in && real_overrun)
        begin
            // Stack segment overrun has its own vector
            next_fault = 1'b1;
            next_vector = operand_is_stack_in ? `STID_VEC_SS : `STID_VEC_GP;
        end
        else if (protected_mode_in && !reg_operand && (limit_violation_in || rights_violation_in))
        begin
            // Only a stack limit overrun maps to the stack vector
            next_fault = 1'b1;
            next_vector = (operand_is_stack_in && limit_violation_in) ? `STID_VEC_SS : `STID_VEC_GP;
        end
        else if (protected_mode_in && next_priv && current_privilege_level_in != 2'h0)
        begin
            // Real mode skips the privilege check on purpose
            next_fault = 1'b1;
            next_vector = `STID_VEC_GP;
        end
    end

    // Start, fault and countdown sequencing; faults complete in one cycle
    always @(posedge clk_sys_in)
    begin
        if (!rstn_in)
        begin
            // All outputs clear in reset
            active <= 1'b0;
            count <= 5'h00;
            cur_op <= `STID_OPS_NONE;
            op_code_out <= `STID_OPS_NONE;
            done_out <= 1'b0;
            fault_out <= 1'b0;
            fault_vector_out <= 8'h00;
            zero_flag_clear_out <= 1'b0;
        end
        else
        begin
            // Pulses default low every cycle
            done_out <= 1'b0;
            fault_out <= 1'b0;
            if (active)
            begin
                // Count down; the last busy cycle raises done
                count <= count - 5'h01;
                if (count == 5'h01)
                begin
                    active <= 1'b0;
                    done_out <= 1'b1;
                    cur_op <= `STID_OPS_NONE;
                end
            end
            else if (take)
            begin
                // Op code shows even when the op faults
                op_code_out <= next_op;
                zero_flag_clear_out <= 1'b0;
                if (next_fault)
                begin
                    // Vector holds until the next fault
                    fault_out <= 1'b1;
                    fault_vector_out <= next_vector;
                end
                else
                begin
                    // Real-mode table and status ops run like protected ones
                    active <= 1'b1;
                    count <= next_count;
                    cur_op <= next_op;
                    zero_flag_clear_out <= is_verify(next_op) && selector_priv_violation_in;
                end
            end
        end
    end

    // Busy mirrors the run flag
    assign busy_out = active;

    // Lock only during descriptor fetches of table ops
    assign bus_lock_out = active && needs_desc(cur_op) && descriptor_fetch_in;

endmodule // stid_decode

// ==== hw/stid_regs.vh ====
// Constants for the protection-control instruction decoder
// Operation
// - 0F 01 /3 loads interrupt table base, 11
// - 0F 00 /2 loads local selector, 20/24
// - 0F 01 /6 loads status word, 11/14
// - 0F 03 loads segment limit, 21/22 or 25/26
// - 0F 00 /3 loads task register, 23/27
// - 0F 01 /0 stores global table base, 9
// - 0F 01 /1 stores interrupt table base, 9
// - 0F 00 /0 stores local selector, 2
// - 0F 01 /4 stores status word, 2
// - 0F 00 /1 stores task register, 2
// - 0F 00 /4 verifies readable, 10/11
// - 0F 00 /5 verifies writable, 15/16
// - Protected-only op in real mode: fault 6
// - Real mode offset past FFFFH: fault 13
// - Real mode stack limit overrun: fault 12
// - Table and status ops allowed in real mode
// - Protected limit/rights violation: 13, stack 12 (a stack rights violation gives 13 here)
// - Privileged loads with privilege above 0: 13 (checked in protected mode only)
// - Lock bus during descriptor table fetches
// - Verify/limit privilege violation clears zero flag
`ifndef STID_REGS_VH
`define STID_REGS_VH
`define STID_ESCAPE 8'h0F
`define STID_OP_GRP0 8'h00
`define STID_OP_GRP1 8'h01
`define STID_OP_SEG_LIMIT 8'h03
`define STID_MOD_REG 2'h3
`define STID_REAL_LIMIT 17'h0FFFF
`define STID_VEC_UD 8'h06
`define STID_VEC_SS 8'h0C
`define STID_VEC_GP 8'h0D
`define STID_OPS_NONE 4'h0
`define STID_OPS_LOAD_INT_BASE 4'h1
`define STID_OPS_LOAD_LOCAL_SEL 4'h2
`define STID_OPS_LOAD_STATUS 4'h3
`define STID_OPS_LIMIT_BYTE 4'h4
`define STID_OPS_LIMIT_PAGE 4'h5
`define STID_OPS_LOAD_TASK 4'h6
`define STID_OPS_STORE_GLOBAL_BASE 4'h7
`define STID_OPS_STORE_INT_BASE 4'h8
`define STID_OPS_STORE_LOCAL_SEL 4'h9
`define STID_OPS_STORE_STATUS 4'hA
`define STID_OPS_STORE_TASK 4'hB
`define STID_OPS_VERIFY_READ 4'hC
`define STID_OPS_VERIFY_WRITE 4'hD
`define STID_CLK_LOAD_INT_BASE 5'h0B
`define STID_CLK_LOAD_STATUS_REG 5'h0B
`define STID_CLK_LOAD_STATUS_MEM 5'h0E
`define STID_CLK_LOAD_LOCAL_REG 5'h14
`define STID_CLK_LOAD_LOCAL_MEM 5'h18
`define STID_CLK_LIMIT_BYTE_REG 5'h15
`define STID_CLK_LIMIT_BYTE_MEM 5'h16
`define STID_CLK_LIMIT_PAGE_REG 5'h19
`define STID_CLK_LIMIT_PAGE_MEM 5'h1A
`define STID_CLK_LOAD_TASK_REG 5'h17
`define STID_CLK_LOAD_TASK_MEM 5'h1B
`define STID_CLK_STORE_BASE 5'h09
`define STID_CLK_STORE_SHORT 5'h02
`define STID_CLK_VERIFY_READ_REG 5'h0A
`define STID_CLK_VERIFY_READ_MEM 5'h0B
`define STID_CLK_VERIFY_WRITE_REG 5'h0F
`define STID_CLK_VERIFY_WRITE_MEM 5'h10
`endif
